//--- core/heater_ctl_pkg.sv
// Constants, types and helpers shared by the heater output control block
package heater_ctl_pkg;
    localparam int RD_W     = 20;
    localparam int GAIN_W   = 14;
    localparam int D_W      = 8;
    localparam int SUM_W    = 24;
    localparam int ACC_W    = 40;
    localparam int NUM_W    = 52;
    localparam int ZONE_COUNT = 10;
    localparam int P_SHIFT  = 4;
    localparam int I_SHIFT  = 12;
    localparam int TICK_HZ  = 10;
    localparam int D_K      = 25 * TICK_HZ;

    typedef logic signed [RD_W-1:0]  reading_t;
    typedef logic signed [RD_W:0]    err_t;
    typedef logic [GAIN_W-1:0]       gain_t;
    typedef logic [D_W-1:0]          deriv_t;
    typedef logic [GAIN_W-1:0]       pct_t;
    typedef logic signed [SUM_W-1:0] sum_t;

    localparam gain_t  P_RESET  = 14'h01F4;
    localparam gain_t  I_RESET  = 14'h00C8;
    localparam gain_t  GAIN_MAX = 14'h2710;
    localparam deriv_t D_RESET  = 8'h00;
    localparam deriv_t D_MAX    = 8'hC8;
    localparam pct_t   PCT_FULL = 14'h2710;
    localparam pct_t   PCT_ZERO = 14'h0000;
    localparam logic [1:0] MODE_CODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_CODE_PID  = 2'h1;
    localparam logic [1:0] MODE_CODE_ZONE = 2'h2;
    localparam logic [1:0] MODE_CODE_OPEN = 2'h3;
    localparam logic [2:0] FB_NONE = 3'h0;
    localparam logic [2:0] FB_A    = 3'h1;
    localparam logic [2:0] FB_B    = 3'h2;
    localparam logic [2:0] FB_C    = 3'h3;
    localparam logic [2:0] FB_D    = 3'h4;
    localparam logic [2:0] RANGE_OFF = 3'h0;

    typedef enum logic [3:0] {
        MODE_OFF  = 4'h1,
        MODE_PID  = 4'h2,
        MODE_ZONE = 4'h4,
        MODE_OPEN = 4'h8
    } mode_t;

    function automatic sum_t clip_sum(input logic signed [63:0] v);
        if (v > 64'sh00000000007FFFFF)
            return sum_t'(24'h7FFFFF);
        else if (v < -64'sh0000000000800000)
            return sum_t'(24'h800000);
        else
            return sum_t'(v);
    endfunction : clip_sum

    function automatic pct_t clip_pct(input sum_t v);
        if (v < 0)
            return PCT_ZERO;
        else if (v > $signed({10'h000, PCT_FULL}))
            return PCT_FULL;
        else
            return pct_t'(v);
    endfunction : clip_pct
endpackage : heater_ctl_pkg

//--- core/heater_ctl_if.sv
// Interfaces between the control top, the PID core and the zone table
`timescale 1ns/100ps
interface pid_if;
    import heater_ctl_pkg::*;
    logic   start;
    err_t   err;
    gain_t  p;
    gain_t  i;
    deriv_t d;
    logic   done;
    sum_t   sum;
    modport ctl  (output start, err, p, i, d, input done, sum);
    modport core (input start, err, p, i, d, output done, sum);
endinterface : pid_if

interface zone_if;
    import heater_ctl_pkg::*;
    logic        wr;
    logic [3:0]  widx;
    reading_t    wbound;
    gain_t       wp;
    gain_t       wi;
    deriv_t      wd;
    reading_t    sp;
    logic [3:0]  zone;
    logic        load;
    gain_t       lp;
    gain_t       li;
    deriv_t      ld;
    modport ctl (output wr, widx, wbound, wp, wi, wd, sp,
                 input zone, load, lp, li, ld);
    modport tbl (input wr, widx, wbound, wp, wi, wd, sp,
                 output zone, load, lp, li, ld);
endinterface : zone_if

//--- core/pid_core.sv
// Three-term computation with a serial divider for the derivative time
`timescale 1ns/100ps
module pid_core (
    input wire logic clock,
    input wire logic rst,
    pid_if.core      pi
);
    import heater_ctl_pkg::*;

    logic                    busy;
    logic [5:0]              cnt;
    logic [NUM_W-1:0]        num;
    logic [GAIN_W:0]         rem;
    gain_t                   div;
    logic                    neg;
    err_t                    prev;
    logic signed [ACC_W-1:0] acc;
    sum_t                    pi_part;

    wire err_t  delta = err_t'(pi.err - prev);
    wire err_t  mag   = delta < 0 ? err_t'(-delta) : delta;
    // Td = d% of Ti/4, Ti = 10000/i seconds: p*Td*rate = p*d*D_K/i
    wire logic [NUM_W-1:0] d_num = (pi.i == 14'h0000) ? '0 :
        NUM_W'(pi.p) * NUM_W'(pi.d) * NUM_W'(mag) * NUM_W'(D_K);
    wire logic signed [ACC_W-1:0] acc_sum = acc + ACC_W'(pi.err)
        * ACC_W'($signed({1'b0, pi.i}));
    wire logic signed [ACC_W-1:0] next_acc = (pi.i == 14'h0000) ? '0 :
        acc_sum;
    wire logic [GAIN_W:0]  rs   = {rem[GAIN_W-1:0], num[NUM_W-1]};
    wire logic             ge   = rs >= {1'b0, div};
    wire logic [GAIN_W:0]  next_rem = ge ? rs - {1'b0, div} : rs;
    wire logic [NUM_W-1:0] next_num = {num[NUM_W-2:0], ge};
    wire logic signed [63:0] d_part = neg ?
        -$signed({12'h000, next_num}) : $signed({12'h000, next_num});
    wire logic signed [63:0] p_part = 64'(pi.err) * $signed({1'b0, pi.p});

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 6'h00;
            num <= '0;
            rem <= '0;
            div <= 14'h0001;
            neg <= 1'b0;
            prev <= '0;
            acc <= '0;
            pi_part <= '0;
            pi.done <= 1'b0;
            pi.sum <= '0;
        end else begin
            pi.done <= 1'b0;
            if (pi.start && !busy) begin
                busy <= 1'b1;
                cnt <= 6'h00;
                num <= d_num;
                rem <= '0;
                div <= (pi.i == 14'h0000) ? 14'h0001 : pi.i;
                neg <= delta < 0;
                prev <= pi.err;
                acc <= next_acc;
                pi_part <= clip_sum((p_part >>> P_SHIFT)
                    + 64'(next_acc >>> I_SHIFT));
            end else if (busy) begin
                num <= next_num;
                rem <= next_rem;
                cnt <= cnt + 6'h01;
                if (cnt == 6'(NUM_W - 1)) begin
                    busy <= 1'b0;
                    pi.done <= 1'b1;
                    pi.sum <= clip_sum(64'(pi_part)
                        + (d_part >>> P_SHIFT));
                end
            end
        end
    end
endmodule : pid_core

//--- core/zone_table.sv
// Zone table: finds the setpoint's zone and loads its parameters
`timescale 1ns/100ps
module zone_table #(
    parameter int ZONES = heater_ctl_pkg::ZONE_COUNT
) (
    input wire logic clock,
    input wire logic rst,
    zone_if.tbl      zi
);
    import heater_ctl_pkg::*;

    if (ZONES < 1 || ZONES > 16) begin : g_check
        $error("zone_table: ZONES must be 1 to 16");
    end

    reading_t   bound [ZONES];
    gain_t      zp    [ZONES];
    gain_t      zi_v  [ZONES];
    deriv_t     zd    [ZONES];
    logic [3:0] found;

    // First zone whose upper bound reaches the setpoint, else the last
    always_comb begin
        found = 4'(ZONES - 1);
        for (int k = ZONES - 1; k >= 0; k--) begin
            if (zi.sp <= bound[k])
                found = 4'(k);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < ZONES; k++) begin
                bound[k] <= '0;
                zp[k] <= P_RESET;
                zi_v[k] <= I_RESET;
                zd[k] <= D_RESET;
            end
            zi.zone <= 4'h0;
            zi.load <= 1'b0;
            zi.lp <= P_RESET;
            zi.li <= I_RESET;
            zi.ld <= D_RESET;
        end else begin
            if (zi.wr && zi.widx < 4'(ZONES)) begin
                bound[zi.widx] <= zi.wbound;
                zp[zi.widx] <= zi.wp;
                zi_v[zi.widx] <= zi.wi;
                zd[zi.widx] <= zi.wd;
            end
            zi.load <= found != zi.zone;
            zi.zone <= found;
            zi.lp <= zp[found];
            zi.li <= zi_v[found];
            zi.ld <= zd[found];
        end
    end
endmodule : zone_table

//--- core/heater_output_ctl.sv
// Heater output control top: modes, feedback choice, output composition
`timescale 1ns/100ps
module heater_output_ctl #(
    parameter logic [2:0] FEEDBACK_DEFAULT = heater_ctl_pkg::FB_A
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Output configuration, taken on cfg_wr
    input  wire logic                   cfg_wr,
    input  wire logic [1:0]             cfg_mode,
    input  wire logic [2:0]             cfg_range,
    input  wire logic [2:0]             cfg_feedback,
    input  wire logic                   cfg_power_units,
    input  wire logic                   cfg_monitor,
    input  wire heater_ctl_pkg::pct_t   cfg_manual,
    // Tuning parameters, taken on param_wr
    input  wire logic                   param_wr,
    input  wire heater_ctl_pkg::gain_t  param_p,
    input  wire heater_ctl_pkg::gain_t  param_i,
    input  wire heater_ctl_pkg::deriv_t param_d,
    // Zone table write
    input  wire logic                   zone_wr,
    input  wire logic [3:0]             zone_idx,
    input  wire heater_ctl_pkg::reading_t zone_bound,
    input  wire heater_ctl_pkg::gain_t  zone_p,
    input  wire heater_ctl_pkg::gain_t  zone_i,
    input  wire heater_ctl_pkg::deriv_t zone_d,
    // Loop inputs
    input  wire heater_ctl_pkg::reading_t setpoint,
    input  wire heater_ctl_pkg::reading_t sensor_a,
    input  wire heater_ctl_pkg::reading_t sensor_b,
    input  wire heater_ctl_pkg::reading_t sensor_c,
    input  wire heater_ctl_pkg::reading_t sensor_d,
    input  wire logic                   control_tick,
    // Heater stage
    output      heater_ctl_pkg::pct_t   heater_level,
    output      logic                   heater_enable,
    output      logic                   heater_power_units,
    output      logic [2:0]             heater_range,
    output      heater_ctl_pkg::reading_t monitor_level,
    // Status
    output      heater_ctl_pkg::mode_t  mode_now,
    output      heater_ctl_pkg::gain_t  active_p,
    output      heater_ctl_pkg::gain_t  active_i,
    output      heater_ctl_pkg::deriv_t active_d,
    output      logic [3:0]             zone_now
);
    import heater_ctl_pkg::*;

    if (FEEDBACK_DEFAULT > FB_D) begin : g_check
        $error("heater_output_ctl: FEEDBACK_DEFAULT out of range");
    end

    pid_if  pid ();
    zone_if zn ();

    logic [2:0] feedback;
    logic       monitor;
    pct_t       manual;
    sum_t       pid_sum;
    logic       pid_busy;

    function automatic mode_t decode_mode(input logic [1:0] code);
        case (code)
            MODE_CODE_PID:  return MODE_PID;
            MODE_CODE_ZONE: return MODE_ZONE;
            MODE_CODE_OPEN: return MODE_OPEN;
            default:        return MODE_OFF;
        endcase
    endfunction : decode_mode

    // Feedback source selection, shared by loop and monitor use
    wire logic fb_valid = feedback != FB_NONE && feedback <= FB_D;
    wire reading_t fb_value =
        (feedback == FB_A) ? sensor_a :
        (feedback == FB_B) ? sensor_b :
        (feedback == FB_C) ? sensor_c :
        (feedback == FB_D) ? sensor_d : '0;
    wire logic closed = mode_now == MODE_PID
        || mode_now == MODE_ZONE;
    wire logic range_on = heater_range != RANGE_OFF;
    wire logic loop_run = closed && fb_valid && !monitor;
    wire pct_t manual_in = (cfg_manual > PCT_FULL) ? PCT_FULL
        : cfg_manual;
    wire logic zone_take = zn.load && mode_now == MODE_ZONE;
    wire sum_t loop_sum = sum_t'(pid_sum
        + $signed({10'h000, manual}));

    // Loop result: a missing feedback source leaves only the manual part
    wire pct_t loop_level = loop_run ? clip_pct(loop_sum)
        : manual;
    wire pct_t next_level =
        (!range_on || monitor) ? PCT_ZERO :
        (mode_now == MODE_OPEN) ? manual :
        closed ? loop_level : PCT_ZERO;

    assign pid.start = control_tick && loop_run && !pid_busy;
    assign pid.err   = err_t'(setpoint) - err_t'(fb_value);
    assign pid.p     = active_p;
    assign pid.i     = active_i;
    assign pid.d     = active_d;

    assign zn.wr     = zone_wr;
    assign zn.widx   = zone_idx;
    assign zn.wbound = zone_bound;
    assign zn.wp     = zone_p;
    assign zn.wi     = zone_i;
    assign zn.wd     = zone_d;
    assign zn.sp     = setpoint;

    pid_core u_pid (
        .clock (clock),
        .rst   (rst),
        .pi    (pid.core)
    );

    zone_table #(
        .ZONES (ZONE_COUNT)
    ) u_zone (
        .clock (clock),
        .rst   (rst),
        .zi    (zn.tbl)
    );

    // Configuration; mode comes out of reset as off
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_now <= MODE_OFF;
            heater_range <= RANGE_OFF;
            feedback <= FEEDBACK_DEFAULT;
            heater_power_units <= 1'b0;
            monitor <= 1'b0;
            manual <= PCT_ZERO;
        end else if (cfg_wr) begin
            mode_now <= decode_mode(cfg_mode);
            heater_range <= cfg_range;
            feedback <= cfg_feedback;
            heater_power_units <= cfg_power_units;
            monitor <= cfg_monitor;
            manual <= manual_in;
        end
    end

    // Zone crossing wins over a manual edit in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active_p <= P_RESET;
            active_i <= I_RESET;
            active_d <= D_RESET;
        end else if (zone_take) begin
            active_p <= zn.lp;
            active_i <= zn.li;
            active_d <= zn.ld;
        end else if (param_wr) begin
            active_p <= (param_p > GAIN_MAX) ? GAIN_MAX : param_p;
            active_i <= (param_i > GAIN_MAX) ? GAIN_MAX : param_i;
            active_d <= (param_d > D_MAX) ? D_MAX : param_d;
        end
    end

    // Stale loop results are dropped once the loop stops running
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pid_busy <= 1'b0;
            pid_sum <= '0;
        end else begin
            pid_busy <= pid.start || (pid_busy && !pid.done);
            if (!loop_run)
                pid_sum <= '0;
            else if (pid.done)
                pid_sum <= pid.sum;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            heater_level <= PCT_ZERO;
            heater_enable <= 1'b0;
            monitor_level <= '0;
            zone_now <= 4'h0;
        end else begin
            heater_level <= next_level;
            heater_enable <= range_on && !monitor
                && mode_now != MODE_OFF;
            monitor_level <= (monitor && fb_valid) ? fb_value
                : '0;
            zone_now <= zn.zone;
        end
    end

    // Checks
    sequence s_start;
        pid.start;
    endsequence

    sequence s_finish;
        ##53 pid.done;
    endsequence

    property p_off_zero;
        @(posedge clock) disable iff (rst)
        mode_now == MODE_OFF |=> heater_level == PCT_ZERO;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("off mode left output nonzero");

    property p_range_off;
        @(posedge clock) disable iff (rst)
        heater_range == RANGE_OFF |=> !heater_enable
            && heater_level == PCT_ZERO;
    endproperty
    a_range_off: assert property (p_range_off)
        else $error("output active with range off");

    property p_open_manual;
        @(posedge clock) disable iff (rst)
        mode_now == MODE_OPEN && range_on && !monitor
            |=> heater_level == $past(manual);
    endproperty
    a_open_manual: assert property (p_open_manual)
        else $error("open loop output differs from manual");

    property p_pid_done;
        @(posedge clock) disable iff (rst)
        s_start |-> s_finish;
    endproperty
    a_pid_done: assert property (p_pid_done)
        else $error("loop computation did not finish on time");

    property p_loop_sum;
        @(posedge clock) disable iff (rst)
        loop_run && range_on ##1 loop_run && range_on
            |=> heater_level == clip_pct(sum_t'($past(pid_sum)
                + $signed({10'h000, $past(manual)})));
    endproperty
    a_loop_sum: assert property (p_loop_sum)
        else $error("manual not added to loop result");

    property p_saturate;
        @(posedge clock) disable iff (rst)
        heater_level <= PCT_FULL && manual <= PCT_FULL;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("output above full scale");

    property p_zone_load;
        @(posedge clock) disable iff (rst)
        zone_take |=> active_p == $past(zn.lp)
            && active_i == $past(zn.li) && active_d == $past(zn.ld);
    endproperty
    a_zone_load: assert property (p_zone_load)
        else $error("zone crossing did not load parameters");

    property p_param_edit;
        @(posedge clock) disable iff (rst)
        param_wr && !zone_take && param_p <= GAIN_MAX
            |=> active_p == $past(param_p);
    endproperty
    a_param_edit: assert property (p_param_edit)
        else $error("manual gain edit not taken");

    property p_reset_state;
        @(posedge clock) disable iff (rst)
        $fell(rst) |-> mode_now == MODE_OFF && active_p == P_RESET
            && active_i == I_RESET && active_d == D_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("wrong state after reset");

    property p_monitor_src;
        @(posedge clock) disable iff (rst)
        monitor && feedback == FB_C |=> monitor_level == $past(sensor_c)
            && heater_level == PCT_ZERO;
    endproperty
    a_monitor_src: assert property (p_monitor_src)
        else $error("monitor level not from selected input");

    property p_mode_onehot;
        @(posedge clock) disable iff (rst)
        $onehot(mode_now);
    endproperty
    a_mode_onehot: assert property (p_mode_onehot)
        else $error("mode is not one of the four");

    property p_mode_code;
        @(posedge clock) disable iff (rst)
        cfg_wr |=> ((mode_now == MODE_OPEN)
            == ($past(cfg_mode) == MODE_CODE_OPEN))
            && ((mode_now == MODE_ZONE)
            == ($past(cfg_mode) == MODE_CODE_ZONE));
    endproperty
    a_mode_code: assert property (p_mode_code)
        else $error("mode code not decoded");

    property p_cfg_take;
        @(posedge clock) disable iff (rst)
        cfg_wr |=> heater_range == $past(cfg_range)
            && heater_power_units == $past(cfg_power_units);
    endproperty
    a_cfg_take: assert property (p_cfg_take)
        else $error("range or unit flag not taken");

    // Monitor use must never source current, whatever the mode says
    property p_monitor_off;
        @(posedge clock) disable iff (rst)
        monitor |=> !heater_enable && heater_level == PCT_ZERO;
    endproperty
    a_monitor_off: assert property (p_monitor_off)
        else $error("heater driven in monitor mode");

    property p_monitor_zero;
        @(posedge clock) disable iff (rst)
        !monitor |=> monitor_level == '0;
    endproperty
    a_monitor_zero: assert property (p_monitor_zero)
        else $error("monitor level outside monitor mode");

    property p_no_source;
        @(posedge clock) disable iff (rst)
        closed && !fb_valid && range_on && !monitor
            |=> heater_level == $past(manual);
    endproperty
    a_no_source: assert property (p_no_source)
        else $error("loop without source not manual only");

    property p_param_clamp;
        @(posedge clock) disable iff (rst)
        param_wr && !zone_take |=> active_p <= GAIN_MAX
            && active_i <= GAIN_MAX && active_d <= D_MAX;
    endproperty
    a_param_clamp: assert property (p_param_clamp)
        else $error("edited parameter beyond its range");

    property p_enable_on;
        @(posedge clock) disable iff (rst)
        range_on && !monitor && mode_now != MODE_OFF |=> heater_enable;
    endproperty
    a_enable_on: assert property (p_enable_on)
        else $error("output not enabled with range on");
endmodule : heater_output_ctl

//--- dv/plant_model.sv
// Far side model: four sensor readings and the heater stage load
`timescale 1ns/100ps
module plant_model (
    // Heater stage side
    input  wire heater_ctl_pkg::pct_t     heater_level,
    input  wire logic                     heater_enable,
    // Sensor side
    output      heater_ctl_pkg::reading_t sensor_a,
    output      heater_ctl_pkg::reading_t sensor_b,
    output      heater_ctl_pkg::reading_t sensor_c,
    output      heater_ctl_pkg::reading_t sensor_d,
    output      heater_ctl_pkg::pct_t     delivered
);
    import heater_ctl_pkg::*;
    // Distinct readings so a wrong feedback choice shows in the result
    assign sensor_a = 20'h00064;
    assign sensor_b = 20'h000C8;
    assign sensor_c = 20'hFFED4;
    assign sensor_d = 20'h00190;
    // Stage sources nothing while disabled, whatever the level says
    assign delivered = heater_enable ? heater_level : PCT_ZERO;
endmodule : plant_model

//--- dv/tb_top.sv
// Self-checking bench for the heater output control block
`timescale 1ns/100ps
module tb_top;
    import heater_ctl_pkg::*;
    typedef struct {
        logic [9:0] cf;
        pct_t       man;
        pct_t       dlv;
        logic       en;
        reading_t   mlv;
        mode_t      mnow;
    } row_t;
    logic       clock, rst, cfg_wr, param_wr, zone_wr, control_tick;
    logic [1:0] cfg_mode;
    logic [2:0] cfg_range, cfg_feedback, heater_range;
    logic       cfg_power_units, cfg_monitor, heater_enable;
    logic       heater_power_units;
    pct_t       cfg_manual, heater_level, delivered;
    gain_t      param_p, param_i, zone_p, zone_i, active_p, active_i;
    deriv_t     param_d, zone_d, active_d;
    logic [3:0] zone_idx, zone_now;
    reading_t   zone_bound, setpoint, sensor_a, sensor_b, sensor_c;
    reading_t   sensor_d, monitor_level;
    mode_t      mode_now;
    int         n_mismatch, checks_done, cycles;
    pct_t       pid_exp [4] = '{14'h0190, 14'h012C, 14'h0320, 14'h0064};
    // cf packs mode, range, feedback, power units, monitor
    row_t rows [7] = '{
        '{10'h324, 14'h1388, 14'h1388, 1'b1, 20'h0, MODE_OPEN},
        '{10'h304, 14'h1388, 14'h0000, 1'b0, 20'h0, MODE_OPEN},
        '{10'h332, 14'h2EE0, PCT_FULL, 1'b1, 20'h0, MODE_OPEN},
        '{10'h050, 14'h0BB8, 14'h0000, 1'b0, 20'h0, MODE_OFF},
        '{10'h32D, 14'h0BB8, 14'h0000, 1'b0, 20'hFFED4, MODE_OPEN},
        '{10'h321, 14'h0BB8, 14'h0000, 1'b0, 20'h0, MODE_OPEN},
        '{10'h120, 14'h0BB8, 14'h0BB8, 1'b1, 20'h0, MODE_PID}};

    heater_output_ctl heater_output_ctl_inst (.*);
    plant_model plant_model_inst (.*);

    initial clock = 1'b0;
    always #5 clock = ~clock;

    task automatic print_verdict;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // A hang is cut short well beyond the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic [1:0] m, input logic [2:0] r,
                       input logic [2:0] f, input logic pw,
                       input logic mon, input pct_t man);
        @(negedge clock);
        {cfg_mode, cfg_range, cfg_feedback} = {m, r, f};
        {cfg_power_units, cfg_monitor, cfg_manual} = {pw, mon, man};
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        repeat (2) @(negedge clock);
    endtask : cfg

    task automatic prm(input gain_t p, input gain_t i, input deriv_t d);
        @(negedge clock);
        {param_p, param_i, param_d} = {p, i, d};
        param_wr = 1'b1;
        @(negedge clock);
        param_wr = 1'b0;
        @(negedge clock);
    endtask : prm

    task automatic zw(input logic [3:0] k, input reading_t b, input gain_t p);
        @(negedge clock);
        {zone_idx, zone_bound, zone_p} = {k, b, p};
        zone_wr = 1'b1;
        @(negedge clock);
        zone_wr = 1'b0;
    endtask : zw

    // Ticks stay far enough apart that every one is taken
    task automatic tick_wait;
        @(negedge clock);
        control_tick = 1'b1;
        @(negedge clock);
        control_tick = 1'b0;
        repeat (58) @(negedge clock);
    endtask : tick_wait

    initial begin
        {cfg_wr, param_wr, zone_wr, control_tick} = 4'h0;
        {cfg_mode, cfg_range, cfg_feedback} = 8'h00;
        {cfg_power_units, cfg_monitor, cfg_manual} = 16'h0000;
        {param_p, param_i, param_d} = 36'h0;
        {zone_idx, zone_bound, zone_p, zone_i, zone_d} = 60'h0;
        setpoint = 20'h001F4;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        foreach (rows[n]) begin
            cfg(rows[n].cf[9:8], rows[n].cf[7:5], rows[n].cf[4:2],
                rows[n].cf[1], rows[n].cf[0], rows[n].man);
            chk(delivered, rows[n].dlv);
            chk(heater_enable, rows[n].en);
            chk(monitor_level, rows[n].mlv);
            chk(mode_now, rows[n].mnow);
            chk(heater_power_units, rows[n].cf[1]);
            chk(heater_range, rows[n].cf[7:5]);
        end
        prm(14'h3FFF, 14'h3FFF, 8'hFF);
        chk(active_p, GAIN_MAX);
        chk(active_i, GAIN_MAX);
        chk(active_d, D_MAX);
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        chk(mode_now, MODE_OFF);
        chk(active_p, P_RESET);
        chk(active_i, I_RESET);
        chk(active_d, D_RESET);
        chk(heater_range, RANGE_OFF);
        chk(delivered, PCT_ZERO);
        chk(heater_power_units, 1'b0);
        prm(14'h0010, 14'h0000, 8'h00);
        for (int f = 1; f <= 4; f++) begin
            cfg(MODE_CODE_PID, 3'h1, f[2:0], 1'b0, 1'b0, PCT_ZERO);
            chk(mode_now, MODE_PID);
            tick_wait();
            chk(heater_level, pid_exp[f-1]);
        end
        cfg(MODE_CODE_PID, 3'h1, FB_A, 1'b0, 1'b0, 14'h01F4);
        tick_wait();
        chk(heater_level, 14'h0384);
        setpoint = 20'h00000;
        cfg(MODE_CODE_PID, 3'h1, FB_A, 1'b0, 1'b0, 14'h0032);
        tick_wait();
        chk(heater_level, PCT_ZERO);
        prm(14'h0010, 14'h03E8, 8'h02);
        setpoint = 20'h001F4;
        tick_wait();
        chk(heater_level, 14'h031D);
        zw(4'h0, 20'h003E8, 14'h0064);
        zw(4'h1, 20'h007D0, 14'h012C);
        cfg(MODE_CODE_ZONE, 3'h1, FB_A, 1'b0, 1'b0, PCT_ZERO);
        chk(mode_now, MODE_ZONE);
        setpoint = 20'h005DC;
        repeat (4) @(negedge clock);
        chk(zone_now, 4'h1);
        chk(active_p, 14'h012C);
        prm(14'h004D, 14'h0000, 8'h00);
        chk(active_p, 14'h004D);
        setpoint = 20'h001F4;
        repeat (4) @(negedge clock);
        chk(active_p, 14'h0064);
        tick_wait();
        chk(heater_level, 14'h09C4);
        print_verdict();
    end
endmodule : tb_top
